// ### design/gpib_status_and_register_window.sv
// Summary of operation
// - Pending set by chip, count, match events
// - Pending cleared by reset or clear write
// - Interrupt output only while enable set
// - Status enable bit mirrors control enable
// - Terminal count when count zero; interrupts
// - Match flag when inbound byte equals value
// - Enabled inbound match interrupts, stops DMA
// - Status shows active-controller line, zero active
// - Status shows chip interrupt line, zero asserted
// - Read-only bus-side FIFO pointer register
// - Read-only processor-side FIFO pointer register
// - Chip registers at FF8 to FFF
// - Status A bit 5: byte received
// - Status A bit 4: room to send
// - Status A bit 3: byte had EOI
// - Status B bit 6: no acceptors error
// - Status B bit 3: device clear active
// - Status B bit 4: secondary passthrough
// - Line levels register shows live lines
// - Direction zero inbound, one outbound
//
// The Wishbone slave port was left to the implementer.
`include "gpib_window_consts.svh"
`default_nettype none

module gpib_status_and_register_window #(
  parameter int PTR_W = 8,
  parameter int CHIP_CYCLES = (`CHIP_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Controller chip pins
  output gpib_window_pkg::chip_bus_s chip_o,
  input wire logic [7:0] chip_rdata_i,
  input wire logic chip_int_n_i,
  input wire logic not_active_ctlr_line_i,
  // DMA engine and FIFO, same clock
  input wire logic [31:0] dma_count_i,
  input wire logic dma_byte_valid_i,
  input wire logic [7:0] dma_byte_i,
  input wire logic [PTR_W-1:0] io_fifo_ptr_i,
  input wire logic [PTR_W-1:0] proc_fifo_ptr_i,
  // Control outputs
  output logic dma_en_o,
  output logic dma_dir_o,
  output logic match_en_o,
  output logic sys_ctlr_en_o,
  output logic irq_o
);

  // Chip window decode, used by the bus logic and by a check
  function automatic logic is_chip(input logic [11:0] idx);
    is_chip = (idx >= `IDX_CHIP_FIRST) && (idx <= `IDX_CHIP_LAST);
  endfunction

  localparam logic [7:0] CHIP_LAST_CNT = 8'(CHIP_CYCLES - 1);

  gpib_window_pkg::window_state_s q, d;
  logic [11:0] idx;
  logic req;
  logic tc_now;
  logic match_rise;

  assign idx = wb_adr_i[13:2];
  // A new request is taken only once the previous ack has dropped
  assign req = wb_cyc_i && wb_stb_i && !q.ack;
  assign tc_now = (dma_count_i == 32'h0000_0000);

  // Next-state logic for the whole block
  always_comb begin
    logic byte_in;
    logic [7:0] byte_val;
    logic wr_lo;
    byte_in = 1'b0;
    byte_val = 8'h00;
    wr_lo = 1'b0;
    match_rise = 1'b0;
    d = q;
    d.ack = 1'b0;
    // Two-flop synchronisers for chip pins
    d.rd_s1 = chip_rdata_i;
    d.rd_s2 = q.rd_s1;
    d.int_s1 = chip_int_n_i;
    d.int_s2 = q.int_s1;
    d.nc_s1 = not_active_ctlr_line_i;
    d.nc_s2 = q.nc_s1;
    d.tc_prev = tc_now;

    case (q.st)
      gpib_window_pkg::ST_IDLE: begin
        if (req && is_chip(idx)) begin
          // Every chip offset, including unused ones, goes out unchanged
          d.chip.rs = idx[2:0];
          d.chip.rd = !wb_we_i;
          d.chip.wr = wb_we_i && wb_sel_i[0];
          d.chip.wdata = wb_dat_i[7:0];
          d.cnt = CHIP_LAST_CNT;
          d.st = gpib_window_pkg::ST_CHIP;
        end else if (req) begin
          d.ack = 1'b1;
          d.dat = 32'h0000_0000;
          wr_lo = wb_we_i && wb_sel_i[0];
          if (idx == `IDX_ISA_CONTROL) begin
            d.dat[`CTL_DMA_EN_BIT] = q.dma_en;
            d.dat[`CTL_IEN_BIT] = q.ien;
            d.dat[`CTL_SYSEN_BIT] = q.sysen;
            if (wr_lo) begin
              d.dma_en = wb_dat_i[`CTL_DMA_EN_BIT];
              d.ien = wb_dat_i[`CTL_IEN_BIT];
              d.sysen = wb_dat_i[`CTL_SYSEN_BIT];
            end
          end else if (idx == `IDX_DMA_CONTROL) begin
            d.dat[`DMA_DIR_BIT] = q.dir;
            d.dat[`DMA_MEN_BIT] = q.men;
            if (wr_lo) begin
              d.dir = wb_dat_i[`DMA_DIR_BIT];
              d.men = wb_dat_i[`DMA_MEN_BIT];
            end
          end else if (idx == `IDX_MATCH_VALUE) begin
            d.dat[7:0] = q.match_val;
            if (wr_lo) begin
              d.match_val = wb_dat_i[7:0];
            end
          end else if (idx == `IDX_CLEAR_IRQ) begin
            if (wb_we_i) begin
              d.pend = 1'b0;
            end
          end else if (idx == `IDX_COMBINED_STATUS) begin
            d.dat[`CST_PEND_BIT] = q.pend;
            d.dat[`CST_IEN_BIT] = q.ien;
            d.dat[`CST_TC_BIT] = q.tc_prev;
            d.dat[`CST_MATCH_BIT] = q.match;
            d.dat[`CST_NOT_ACTIVE_CTLR_LINE_BIT] = q.nc_s2;
            d.dat[`CST_CHIP_INT_BIT] = q.int_s2;
          end else if (idx == `IDX_IO_FIFO_PTR) begin
            d.dat[PTR_W-1:0] = io_fifo_ptr_i;
          end else if (idx == `IDX_PROC_FIFO_PTR) begin
            d.dat[PTR_W-1:0] = proc_fifo_ptr_i;
          end
          // Unmapped indices answer with zero and no side effect
        end
      end
      gpib_window_pkg::ST_CHIP: begin
        if (q.cnt == 8'h00) begin
          d.chip.rd = 1'b0;
          d.chip.wr = 1'b0;
          d.ack = 1'b1;
          d.dat = 32'h0000_0000;
          // Chip status and line bytes pass through bit for bit
          d.dat[7:0] = q.rd_s2;
          d.st = gpib_window_pkg::ST_IDLE;
          // Parenthesised compare; a bare mask here would bind looser than the equality
          if (q.chip.rd && (q.chip.rs == 3'(`IDX_BYTE_RECEIVED)) && q.dir == `DIR_INBOUND) begin
            byte_in = 1'b1;
            byte_val = q.rd_s2;
          end
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      default: begin
        d.st = gpib_window_pkg::ST_IDLE;
      end
    endcase

    // Inbound bytes from the DMA engine also feed the matcher
    if (dma_byte_valid_i && q.dir == `DIR_INBOUND) begin
      byte_in = 1'b1;
      byte_val = dma_byte_i;
    end
    if (byte_in) begin
      d.match = (byte_val == q.match_val);
    end
    match_rise = d.match && !q.match;

    // Events are applied last so a set beats a clear in the same cycle
    if (!q.int_s2) begin
      d.pend = 1'b1;
    end
    if (tc_now && !q.tc_prev) begin
      d.pend = 1'b1;
    end
    if (match_rise) begin
      d.pend = 1'b1;
      if (q.men && q.dir == `DIR_INBOUND && q.ien) begin
        d.dma_en = 1'b0;
      end
    end
    d.irq = d.pend && d.ien;
  end

  // State register; reset returns every control bit to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= gpib_window_pkg::ST_IDLE;
      q.int_s1 <= `RST_CHIP_INT_N;
      q.int_s2 <= `RST_CHIP_INT_N;
      q.nc_s1 <= `RST_NOT_ACTIVE_CTLR_LINE;
      q.nc_s2 <= `RST_NOT_ACTIVE_CTLR_LINE;
      q.dma_en <= `RST_CONTROL;
      q.ien <= `RST_CONTROL;
      q.sysen <= `RST_CONTROL;
      q.match_val <= `RST_MATCH_VALUE;
      q.pend <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign chip_o = q.chip;
  assign dma_en_o = q.dma_en;
  assign dma_dir_o = q.dir;
  assign match_en_o = q.men;
  assign sys_ctlr_en_o = q.sysen;
  assign irq_o = q.irq;

  // Checks
  a_pend_reset_zero: assert property (@(posedge clk_i) rst_i |=> !q.pend)
    else $error("pending flag not cleared by reset");

  a_irq_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> (q.ien && q.pend))
    else $error("interrupt driven without enable or pending");

  a_chip_int_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.int_s2 |=> q.pend)
    else $error("chip interrupt did not set pending");

  a_tc_edge_pend: assert property (@(posedge clk_i) disable iff (rst_i)
    (tc_now && !q.tc_prev) |=> (q.pend && q.tc_prev))
    else $error("terminal count edge did not set pending");

  a_match_stop_dma: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(q.match) && $past(q.men && !q.dir && q.ien)) |-> (!q.dma_en && q.pend))
    else $error("enabled match did not stop DMA");

  a_match_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (dma_byte_valid_i && !q.dir && dma_byte_i == q.match_val) |=> q.match)
    else $error("matching inbound byte did not set match flag");

  a_ien_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && !wb_we_i && idx == `IDX_COMBINED_STATUS) |-> wb_dat_o[`CST_IEN_BIT] == q.ien)
    else $error("status enable bit differs from control");

  a_chip_select: assert property (@(posedge clk_i) disable iff (rst_i)
    (chip_o.rd || chip_o.wr) |-> (chip_o.rs == wb_adr_i[4:2] && is_chip(idx)))
    else $error("chip strobe with wrong register select");

  a_chip_ack_end: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(chip_o.rd || chip_o.wr) |-> wb_ack_o ##1 !wb_ack_o)
    else $error("chip access end not acknowledged for one cycle");

endmodule // gpib_status_and_register_window
`default_nettype wire

// ### common/gpib_window_consts.svh
`ifndef GPIB_WINDOW_CONSTS_SVH
`define GPIB_WINDOW_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_IRQ_STATUS_A 12'hff8
`define IDX_IRQ_STATUS_B 12'hff9
`define IDX_ADDRESS_STATE 12'hffa
`define IDX_LINE_LEVELS 12'hffb
`define IDX_UNUSED_READ_A 12'hffc
`define IDX_UNUSED_READ_B 12'hffd
`define IDX_CMD_PASSTHROUGH 12'hffe
`define IDX_BYTE_RECEIVED 12'hfff
`define IDX_CHIP_FIRST 12'hff8
`define IDX_CHIP_LAST 12'hfff
`define IDX_ISA_CONTROL 12'h7ff
`define IDX_DMA_CONTROL 12'h808
`define IDX_MATCH_VALUE 12'h809
`define IDX_CLEAR_IRQ 12'h80a
`define IDX_COMBINED_STATUS 12'h811
`define IDX_IO_FIFO_PTR 12'h812
`define IDX_PROC_FIFO_PTR 12'h813

// Interface control fields
`define CTL_DMA_EN_BIT 0
`define CTL_IEN_BIT 2
`define CTL_SYSEN_BIT 3
// DMA control fields
`define DMA_DIR_BIT 0
`define DMA_MEN_BIT 1
// Combined status fields
`define CST_PEND_BIT 7
`define CST_IEN_BIT 6
`define CST_TC_BIT 5
`define CST_MATCH_BIT 4
`define CST_NOT_ACTIVE_CTLR_LINE_BIT 1
`define CST_CHIP_INT_BIT 0

// Controller chip field positions, passed through unchanged
`define CHIP_A_RX_BYTE_READY_BIT 5
`define CHIP_A_TX_BYTE_ROOM_BIT 4
`define CHIP_A_END_BIT 3
`define CHIP_B_ERR_BIT 6
`define CHIP_B_SECONDARY_ADDR_PASSTHRU_BIT 4
`define CHIP_B_DEVICE_CLEAR_ACTIVE_BIT 3
`define CHIP_LINE_DAV_BIT 6
`define CHIP_PRIMARY_BUS_ADDRESS_MSB 4

// Reset values
`define RST_CONTROL 1'b0
`define RST_MATCH_VALUE 8'h00
`define RST_CHIP_INT_N 1'b1
`define RST_NOT_ACTIVE_CTLR_LINE 1'b1
`define DIR_INBOUND 1'b0

// Chip strobe width and clock period in nanoseconds (100 MHz clock)
`define CHIP_STROBE_NS 60
`define CLK_PERIOD_NS 10

`endif

// ### common/gpib_window_pkg.sv
`default_nettype none
package gpib_window_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CHIP
  } bus_state_e;

  // Pins toward the controller chip
  typedef struct packed {
    logic [2:0] rs;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } chip_bus_s;

  // Whole state of the window block
  typedef struct packed {
    bus_state_e st;
    logic [7:0] cnt;
    logic ack;
    logic [31:0] dat;
    chip_bus_s chip;
    logic [7:0] rd_s1;
    logic [7:0] rd_s2;
    logic int_s1;
    logic int_s2;
    logic nc_s1;
    logic nc_s2;
    logic dma_en;
    logic ien;
    logic sysen;
    logic dir;
    logic men;
    logic [7:0] match_val;
    logic pend;
    logic tc_prev;
    logic match;
    logic irq;
  } window_state_s;

endpackage
`default_nettype wire

// ### tb/gpib_chip_model.sv
`default_nettype none
module gpib_chip_model (
  // Clock
  input wire logic clk_i,
  // Strobes from the window
  input wire gpib_window_pkg::chip_bus_s chip_i,
  // Read data and captured writes
  output logic [7:0] rdata_o,
  output logic [7:0][7:0] wregs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0][7:0] rregs;
  logic [7:0] last_q;
  logic wr_q;
  // Read side: status bits, live line levels, received bytes
  initial begin
    rregs[0] = 8'h38;
    rregs[1] = 8'h58;
    rregs[2] = 8'h91;
    rregs[3] = 8'h40;
    rregs[4] = 8'h6c;
    rregs[5] = 8'h2b;
    rregs[6] = 8'ha7;
    rregs[7] = 8'h5e;
    wregs_o = '0;
    last_q = 8'h00;
    wr_q = 1'b0;
  end
  // A released bus shows the inverse of the last byte, so stale data never matches
  assign rdata_o = chip_i.rd ? rregs[chip_i.rs] : ~last_q;
  // Write lands when the strobe falls
  always @(posedge clk_i) begin
    wr_q <= chip_i.wr;
    if (chip_i.rd) last_q <= rregs[chip_i.rs];
    if (wr_q && !chip_i.wr) wregs_o[chip_i.rs] <= chip_i.wdata;
  end
endmodule // gpib_chip_model
`default_nettype wire

// ### tb/gpib_status_and_register_window_tb.sv
`default_nettype none
module gpib_status_and_register_window_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [13:0] adr = '0;
  logic [31:0] wdat = '0, wb_dat_o, cnt = 32'h0000_0001;
  logic wb_ack_o, int_n = 1'b1, not_active_ctlr_line = 1'b1, bval = 1'b0;
  logic [7:0] bdat = 8'h00, rdata, q;
  logic [7:0][7:0] wregs;
  logic dma_en_o, dma_dir_o, match_en_o, sys_ctlr_en_o, irq_o;
  gpib_window_pkg::chip_bus_s chip;
  int miscompares = 0, total_checks = 0, cycles = 0;
  gpib_status_and_register_window #(.CHIP_CYCLES(3)) i_gpib_status_and_register_window (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chip_o(chip),
    .chip_rdata_i(rdata), .chip_int_n_i(int_n), .not_active_ctlr_line_i(not_active_ctlr_line), .dma_count_i(cnt),
    .dma_byte_valid_i(bval), .dma_byte_i(bdat), .io_fifo_ptr_i(8'h5a), .proc_fifo_ptr_i(8'ha5),
    .dma_en_o(dma_en_o), .dma_dir_o(dma_dir_o), .match_en_o(match_en_o),
    .sys_ctlr_en_o(sys_ctlr_en_o), .irq_o(irq_o));
  gpib_chip_model i_gpib_chip_model (.clk_i(clk_i), .chip_i(chip), .rdata_o(rdata), .wregs_o(wregs));
  // Clock and hang guard
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // One classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [11:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(n, e, q);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    wait_clk(6);
    rst_i <= 1'b0;
    wait_clk(3);
    rd("status", 12'h811, 8'h03);
    rd("io_ptr", 12'h812, 8'h5a);
    wb(1'b1, 12'h813, 8'h00);
    rd("proc_ptr", 12'h813, 8'ha5);
    rd("unmapped", 12'h100, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd("chip_read", 12'hff8 + 12'(i), i_gpib_chip_model.rregs[i]);
      wb(1'b1, 12'hff8 + 12'(i), 8'h80 + 8'(i));
      wait_clk(2);
      chk("chip_write", 8'h80 + 8'(i), wregs[i]);
    end
    wb(1'b1, 12'h7ff, 8'h04);
    rd("ien", 12'h811, 8'h43);
    chk("irq_idle", 8'h00, {7'h00, irq_o});
    cnt <= 32'h0000_0000;
    wait_clk(3);
    rd("tc", 12'h811, 8'he3);
    chk("irq_tc", 8'h01, {7'h00, irq_o});
    cnt <= 32'h0000_0001;
    wb(1'b1, 12'h80a, 8'h00);
    rd("cleared", 12'h811, 8'h43);
    chk("irq_clr", 8'h00, {7'h00, irq_o});
    wb(1'b1, 12'h7ff, 8'h00);
    cnt <= 32'h0000_0000;
    wait_clk(3);
    rd("masked", 12'h811, 8'ha3);
    chk("irq_masked", 8'h00, {7'h00, irq_o});
    cnt <= 32'h0000_0001;
    wb(1'b1, 12'h80a, 8'h00);
    wb(1'b1, 12'h809, 8'h0a);
    wb(1'b1, 12'h808, 8'h02);
    wb(1'b1, 12'h7ff, 8'h05);
    chk("ctl", 8'h05, {5'h00, match_en_o, dma_dir_o, dma_en_o});
    @(posedge clk_i);
    bval <= 1'b1;
    bdat <= 8'h0a;
    @(posedge clk_i);
    bval <= 1'b0;
    wait_clk(2);
    chk("halt", 8'h00, {7'h00, dma_en_o});
    rd("match", 12'h811, 8'hd3);
    chk("irq_match", 8'h01, {7'h00, irq_o});
    wb(1'b1, 12'h7ff, 8'h05);
    wait_clk(1);
    chk("resume", 8'h01, {7'h00, dma_en_o});
    wb(1'b1, 12'h80a, 8'h00);
    wb(1'b1, 12'h808, 8'h01);
    rd("dma_ctl", 12'h808, 8'h01);
    chk("dir", 8'h02, {6'h00, dma_dir_o, match_en_o});
    int_n <= 1'b0;
    not_active_ctlr_line <= 1'b0;
    wait_clk(4);
    rd("lines", 12'h811, 8'hd0);
    int_n <= 1'b1;
    wb(1'b1, 12'h7ff, 8'h08);
    wait_clk(1);
    chk("sysen", 8'h01, {7'h00, sys_ctlr_en_o});
    tally_and_finish();
  end
endmodule // gpib_status_and_register_window_tb
`default_nettype wire
